// ===== verilog/pclb_pkg.sv
package pclb_pkg;
   // Channel count and control link timing
   localparam int NUM_CH = 32;
   localparam int LINK_KHZ = 2048;
   localparam int FRAME_US = 125;
   localparam int MFRAME_MS = 4;
   localparam int BITS_PER_SLOT = 8;
   localparam int SLOTS_PER_FRAME = LINK_KHZ * FRAME_US / 1000 / BITS_PER_SLOT;
   localparam int FRAMES_PER_MF = MFRAME_MS * 1000 / FRAME_US;
   localparam int FIFO_DEPTH = 4;

   // Bit phase positions of the 8192 kHz system bit clock
   localparam logic [1:0] SAMPLE_PHASE = 2'h2;
   localparam logic [1:0] DRIVE_PHASE = 2'h0;
   localparam logic [1:0] LAST_PHASE = 2'h3;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [4:0] LAST_SLOT = 5'(SLOTS_PER_FRAME - 1);
   localparam logic [4:0] LAST_FRAME = 5'(FRAMES_PER_MF - 1);
   localparam logic [4:0] CTRL_SLOT = 5'h00;

   // Field positions of the control byte carried in slot 0
   localparam int CMD_OFF_POS = 7;
   localparam int CMD_BYPASS_POS = 6;
   localparam int CMD_CONV_POS = 5;
   localparam int CMD_NLP_POS = 4;

   // Law encoding and reset values
   localparam logic LAW_A = 1'b1;
   localparam logic LAW_MU = 1'b0;
   localparam logic [7:0] RX_RESET = 8'h00;
   localparam logic [1:0] PHASE_RESET = 2'h0;

   typedef enum logic {LINK_IDLE, LINK_RUN} pclb_link_state_t;

   typedef struct packed {
      logic off_chan;
      logic bypass;
      logic conv_off;
      logic nlp_off;
   } pclb_cmd_t;

   localparam pclb_cmd_t CMD_RESET = 4'h0;

   typedef struct packed {
      logic [4:0] chan;
      logic [7:0] send_in;
      logic [7:0] recv_in;
      logic [7:0] ec_send;
      logic [7:0] ec_recv;
      logic mf_begin;
      logic robbed;
      logic tone;
      logic serial_bypass;
      logic serial_conv_off;
   } pclb_in_t;

   typedef struct packed {
      logic [4:0] chan;
      logic [7:0] send_out;
      logic [7:0] recv_out;
      logic mf_begin;
      logic fe_law;
      logic ne_law;
      logic conv_on;
      logic bypass;
      logic nlp_skip;
      logic coef_reset;
      logic speech_reset;
      logic clear64;
      logic full_skip;
      logic loop_rs;
      logic loop_sr;
   } pclb_out_t;
endpackage

// ===== verilog/pclb_fifo.sv
`timescale 1ns/100ps
module pclb_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   // Clock, reset, enable
   input logic mclk,
   input logic reset,
   input logic ce,
   // Filling side
   input logic in_valid,
   output logic in_ready,
   input logic [WIDTH-1:0] in_data,
   // Draining side
   output logic out_valid,
   input logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   // Honest flags straight from the occupancy count
   assign in_ready = (cnt_q != DEPTH_C);
   assign out_valid = (cnt_q != '0);
   assign push = ce & in_valid & in_ready;
   assign pop = ce & out_valid & out_ready;
   assign out_data = mem_q[rd_q];

   // Storage words
   always_ff @(posedge mclk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   // Pointers and count
   always_ff @(posedge mclk) begin
      if (reset) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == LAST_C) ? '0 : AW'(wr_q + 1'b1);
         end
         if (pop) begin
            rd_q <= (rd_q == LAST_C) ? '0 : AW'(rd_q + 1'b1);
         end
         if (push && !pop) begin
            cnt_q <= (AW+1)'(cnt_q + 1'b1);
         end else if (pop && !push) begin
            cnt_q <= (AW+1)'(cnt_q - 1'b1);
         end
      end
   end
endmodule // pclb_fifo

// ===== verilog/pclb_ctrl.sv
`timescale 1ns/100ps
module pclb_ctrl #(
   parameter int NUM_CH = pclb_pkg::NUM_CH,
   parameter int FIFO_DEPTH = pclb_pkg::FIFO_DEPTH
) (
   // Clock, reset, enable
   input logic mclk,
   input logic reset,
   input logic ce,
   // Law configuration
   input logic per_channel_law_mode,
   input logic global_far_end_law,
   input logic global_near_end_law,
   input logic global_off_law,
   input logic [NUM_CH-1:0] indiv_far_end_law,
   input logic [NUM_CH-1:0] indiv_near_end_law,
   input logic [NUM_CH-1:0] conversion_off,
   input logic [NUM_CH-1:0] channel_off_law,
   input logic [NUM_CH-1:0] pin_control_gate,
   // Bypass, disable and test configuration
   input logic [NUM_CH-1:0] channel_disable,
   input logic canceller_disable,
   input logic nonlinear_off_pin,
   input logic nonlinear_off_reg,
   input logic [2:0] tone_action,
   input logic send_path_skip,
   input logic receive_path_skip,
   input logic receive_to_send_loop,
   input logic send_to_receive_loop,
   // Control link pins and alignment
   input logic sys_bit_clk,
   input logic frame_sync_in,
   input logic control_link_in,
   output logic control_link_out,
   output logic control_link_oe,
   input logic [4:0] control_link_frame_offset,
   input logic [4:0] control_link_channel_offset,
   input logic [1:0] bit_phase_offset,
   input logic gp_frame_en,
   input logic [4:0] gp_frame_sel,
   output logic [7:0] gp_byte,
   output logic gp_strobe,
   output logic link_locked,
   // Sample stream in
   input logic in_valid,
   output logic in_ready,
   input pclb_pkg::pclb_in_t in_word,
   // Sample stream out
   output logic out_valid,
   input logic out_ready,
   output pclb_pkg::pclb_out_t out_word
);
   localparam int OW = $bits(pclb_pkg::pclb_out_t);

   // Pick the law for one end of one channel
   function automatic logic law_pick(input logic per_mode, input logic g_law,
                                     input logic i_law, input logic off,
                                     input logic g_off, input logic c_off);
      logic r;
      r = per_mode ? i_law : g_law;
      if (off) begin
         r = per_mode ? c_off : g_off;
      end
      return r;
   endfunction

   // Three-stage pin synchronisers for bit clock, sync and link data
   logic [2:0] pin_raw;
   logic [2:0] s1_q;
   logic [2:0] s2_q;
   logic [2:0] s3_q;
   logic [2:0] lvl_q;
   logic [2:0] lvl_d;
   assign pin_raw = {control_link_in, frame_sync_in, sys_bit_clk};

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_sync
         // Level moves only once stages two and three agree
         assign lvl_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : lvl_q[gi];
         always_ff @(posedge mclk) begin
            if (reset) begin
               s1_q[gi] <= 1'b0;
               s2_q[gi] <= 1'b0;
               s3_q[gi] <= 1'b0;
               lvl_q[gi] <= 1'b0;
            end else if (ce) begin
               s1_q[gi] <= pin_raw[gi];
               s2_q[gi] <= s1_q[gi];
               s3_q[gi] <= s2_q[gi];
               lvl_q[gi] <= lvl_d[gi];
            end
         end
      end
   endgenerate

   logic bclk_fall;
   logic fs_rise;
   logic link_din;
   assign bclk_fall = lvl_q[0] & ~lvl_d[0];
   assign fs_rise = ~lvl_q[1] & lvl_d[1];
   assign link_din = lvl_q[2];

   // Link position counters
   pclb_pkg::pclb_link_state_t state_q;
   logic [1:0] phase_q;
   logic [2:0] bit_q;
   logic [4:0] slot_q;
   logic [4:0] frame_q;
   logic [1:0] ph_n;
   logic [2:0] bit_n;
   logic [4:0] slot_n;
   logic [4:0] frame_n;

   // Next position after one falling bit clock edge
   always_comb begin
      ph_n = 2'(phase_q + 2'h1);
      bit_n = bit_q;
      slot_n = slot_q;
      frame_n = frame_q;
      if (phase_q == pclb_pkg::LAST_PHASE) begin
         bit_n = 3'(bit_q + 3'h1);
         if (bit_q == pclb_pkg::LAST_BIT) begin
            slot_n = (slot_q == pclb_pkg::LAST_SLOT) ? 5'h00 :
                     5'(slot_q + 5'h01);
            if (slot_q == pclb_pkg::LAST_SLOT) begin
               frame_n = (frame_q == pclb_pkg::LAST_FRAME) ? 5'h00 :
                         5'(frame_q + 5'h01);
            end
         end
      end
   end

   // Sync pulse loads the offsets, so each device sees its own slot 0
   always_ff @(posedge mclk) begin
      if (reset) begin
         state_q <= pclb_pkg::LINK_IDLE;
         phase_q <= pclb_pkg::PHASE_RESET;
         bit_q <= 3'h0;
         slot_q <= 5'h00;
         frame_q <= 5'h00;
      end else if (ce) begin
         if (fs_rise) begin
            state_q <= pclb_pkg::LINK_RUN;
            phase_q <= bit_phase_offset;
            bit_q <= 3'h0;
            slot_q <= control_link_channel_offset;
            frame_q <= control_link_frame_offset;
         end else if (bclk_fall) begin
            case (state_q)
               pclb_pkg::LINK_RUN: begin
                  phase_q <= ph_n;
                  bit_q <= bit_n;
                  slot_q <= slot_n;
                  frame_q <= frame_n;
               end
               default: begin
                  phase_q <= phase_q;
               end
            endcase
         end
      end
   end

   logic run;
   logic sample_ev;
   logic drive_ev;
   logic last_bit_ev;
   logic gp_hit;
   logic wr_ev;
   logic [7:0] rx_byte;
   assign run = (state_q == pclb_pkg::LINK_RUN);
   assign sample_ev = ce & run & bclk_fall & ~fs_rise &
                      (ph_n == pclb_pkg::SAMPLE_PHASE) &
                      (slot_n == pclb_pkg::CTRL_SLOT);
   assign drive_ev = ce & run & bclk_fall & ~fs_rise &
                     (ph_n == pclb_pkg::DRIVE_PHASE);
   assign last_bit_ev = sample_ev & (bit_n == pclb_pkg::LAST_BIT);
   assign gp_hit = gp_frame_en & (frame_n == gp_frame_sel);
   assign wr_ev = last_bit_ev & ~gp_hit;
   assign link_locked = run;

   // Incoming control bits, MSB first
   logic [7:0] rx_q;
   assign rx_byte = {rx_q[6:0], link_din};
   always_ff @(posedge mclk) begin
      if (reset) begin
         rx_q <= pclb_pkg::RX_RESET;
      end else if (sample_ev) begin
         rx_q <= rx_byte;
      end
   end

   // Per-channel commands written straight from the link
   pclb_pkg::pclb_cmd_t cmd_q [NUM_CH];
   pclb_pkg::pclb_cmd_t wr_val;
   assign wr_val = {rx_byte[pclb_pkg::CMD_OFF_POS],
                    rx_byte[pclb_pkg::CMD_BYPASS_POS],
                    rx_byte[pclb_pkg::CMD_CONV_POS],
                    rx_byte[pclb_pkg::CMD_NLP_POS]};
   always_ff @(posedge mclk) begin
      if (reset) begin
         for (int i = 0; i < NUM_CH; i++) begin
            cmd_q[i] <= pclb_pkg::CMD_RESET;
         end
      end else if (wr_ev) begin
         cmd_q[frame_n] <= wr_val;
      end
   end

   // General purpose frame byte, one-cycle strobe
   always_ff @(posedge mclk) begin
      if (reset) begin
         gp_byte <= 8'h00;
         gp_strobe <= 1'b0;
      end else if (ce) begin
         gp_strobe <= last_bit_ev & gp_hit;
         if (last_bit_ev && gp_hit) begin
            gp_byte <= rx_byte;
         end
      end
   end

   // Status byte reported for one channel
   function automatic logic [7:0] status_byte(input pclb_pkg::pclb_cmd_t c,
                                              input logic sw_off,
                                              input logic cv_off,
                                              input logic fe, input logic ne);
      return {c, sw_off, cv_off, fe, ne};
   endfunction

   logic [7:0] tx_byte;
   logic tx_fe;
   logic tx_ne;
   assign tx_fe = law_pick(per_channel_law_mode, global_far_end_law,
                           indiv_far_end_law[frame_n], conversion_off[frame_n],
                           global_off_law, channel_off_law[frame_n]);
   assign tx_ne = law_pick(per_channel_law_mode, global_near_end_law,
                           indiv_near_end_law[frame_n], conversion_off[frame_n],
                           global_off_law, channel_off_law[frame_n]);
   assign tx_byte = status_byte(cmd_q[frame_n], channel_disable[frame_n],
                                conversion_off[frame_n], tx_fe, tx_ne);

   // Output follows the input bit grid; released outside slot 0
   always_ff @(posedge mclk) begin
      if (reset) begin
         control_link_out <= 1'b0;
         control_link_oe <= 1'b0;
      end else if (drive_ev) begin
         control_link_oe <= (slot_n == pclb_pkg::CTRL_SLOT);
         control_link_out <= (slot_n == pclb_pkg::CTRL_SLOT) &
                             tx_byte[~bit_n];
      end
   end

   // Per-sample path decisions
   pclb_pkg::pclb_cmd_t ccmd;
   pclb_pkg::pclb_out_t word_d;
   logic [4:0] ch;
   logic conv_dis;
   logic chan_off;
   logic tone_hit;
   logic skip;
   always_comb begin
      ch = in_word.chan;
      ccmd = cmd_q[ch];
      // Serial and link sources only count when the pin gate is low
      conv_dis = conversion_off[ch] | (~pin_control_gate[ch] &
                 (in_word.serial_conv_off | ccmd.conv_off));
      chan_off = channel_disable[ch] | canceller_disable | ccmd.off_chan;
      tone_hit = in_word.tone;
      word_d.chan = ch;
      word_d.mf_begin = in_word.mf_begin;
      // Laws never depend on bypass or disable
      word_d.fe_law = law_pick(per_channel_law_mode, global_far_end_law,
                               indiv_far_end_law[ch], conv_dis,
                               global_off_law, channel_off_law[ch]);
      word_d.ne_law = law_pick(per_channel_law_mode, global_near_end_law,
                               indiv_near_end_law[ch], conv_dis,
                               global_off_law, channel_off_law[ch]);
      word_d.conv_on = ~conv_dis;
      word_d.bypass = chan_off | in_word.serial_bypass | ccmd.bypass |
                      (tone_hit & tone_action[0]);
      word_d.nlp_skip = nonlinear_off_pin | nonlinear_off_reg |
                        ccmd.nlp_off | (tone_hit & tone_action[1]);
      word_d.coef_reset = chan_off | (tone_hit & tone_action[2]);
      word_d.speech_reset = chan_off;
      word_d.full_skip = send_path_skip & receive_path_skip;
      word_d.clear64 = word_d.bypass &
                       (word_d.fe_law == word_d.ne_law);
      word_d.loop_rs = receive_to_send_loop;
      word_d.loop_sr = send_to_receive_loop & ~receive_to_send_loop;
      skip = word_d.bypass | word_d.full_skip | send_path_skip;
      word_d.send_out = skip ? in_word.send_in : in_word.ec_send;
      if (in_word.robbed) begin
         word_d.send_out[0] = in_word.send_in[0];
      end
      word_d.recv_out = (word_d.bypass | word_d.full_skip | receive_path_skip) ?
                        in_word.recv_in : in_word.ec_recv;
   end

   // One pipeline stage ahead of the FIFO; stalls when the FIFO is full
   pclb_pkg::pclb_out_t st_q;
   logic st_v_q;
   logic f_ready;
   logic accept;
   assign in_ready = ~st_v_q | f_ready;
   assign accept = ce & in_valid & in_ready;
   always_ff @(posedge mclk) begin
      if (reset) begin
         st_v_q <= 1'b0;
         st_q <= '0;
      end else if (ce) begin
         st_v_q <= accept | (st_v_q & ~f_ready);
         if (accept) begin
            st_q <= word_d;
         end
      end
   end

   // Sample and multiframe mark share one word, so delays match
   logic [OW-1:0] f_out;
   pclb_fifo #(.WIDTH(OW), .DEPTH(FIFO_DEPTH)) u_fifo (
      .mclk(mclk),
      .reset(reset),
      .ce(ce),
      .in_valid(st_v_q),
      .in_ready(f_ready),
      .in_data(st_q),
      .out_valid(out_valid),
      .out_ready(out_ready),
      .out_data(f_out)
   );
   assign out_word = f_out;

   // Checks
   property p_oe_slot;
      @(posedge mclk) disable iff (reset)
      $rose(control_link_oe) |-> (slot_q == pclb_pkg::CTRL_SLOT) && run;
   endproperty
   a_oe_slot: assert property (p_oe_slot)
      else $error("link output enabled outside slot 0");

   property p_out_grid;
      @(posedge mclk) disable iff (reset)
      $changed(control_link_out) |-> $past(drive_ev) &&
                                     (phase_q == pclb_pkg::DRIVE_PHASE);
   endproperty
   a_out_grid: assert property (p_out_grid)
      else $error("link output moved off phase 0");

   property p_cmd_write;
      @(posedge mclk) disable iff (reset)
      wr_ev |=> cmd_q[$past(frame_n)] == $past(wr_val);
   endproperty
   a_cmd_write: assert property (p_cmd_write)
      else $error("link command not stored");

   property p_robbed;
      @(posedge mclk) disable iff (reset)
      accept && in_word.robbed |=> st_q.send_out[0] == $past(in_word.send_in[0]);
   endproperty
   a_robbed: assert property (p_robbed)
      else $error("robbed bit not passed through");

   property p_global_law;
      @(posedge mclk) disable iff (reset)
      accept && !per_channel_law_mode && !conv_dis |=>
         st_q.fe_law == $past(global_far_end_law) &&
         st_q.ne_law == $past(global_near_end_law);
   endproperty
   a_global_law: assert property (p_global_law)
      else $error("global law not applied");

   property p_off_law;
      @(posedge mclk) disable iff (reset)
      accept && conv_dis |=> st_q.fe_law == st_q.ne_law && !st_q.conv_on;
   endproperty
   a_off_law: assert property (p_off_law)
      else $error("disabled conversion law mismatch");

   property p_disable;
      @(posedge mclk) disable iff (reset)
      accept && chan_off |=> st_q.bypass && st_q.coef_reset && st_q.speech_reset;
   endproperty
   a_disable: assert property (p_disable)
      else $error("disable did not force bypass and resets");

   property p_loops;
      @(posedge mclk) disable iff (reset)
      st_v_q |-> !(st_q.loop_rs && st_q.loop_sr);
   endproperty
   a_loops: assert property (p_loops)
      else $error("both loops active");

   property p_clear64;
      @(posedge mclk) disable iff (reset)
      st_v_q |-> st_q.clear64 == (st_q.bypass && st_q.fe_law == st_q.ne_law);
   endproperty
   a_clear64: assert property (p_clear64)
      else $error("clear 64 flag wrong");

   property p_nlp;
      @(posedge mclk) disable iff (reset)
      accept && (nonlinear_off_pin || nonlinear_off_reg) |=> st_q.nlp_skip;
   endproperty
   a_nlp: assert property (p_nlp)
      else $error("nonlinear processor not skipped");
endmodule // pclb_ctrl

// ===== testbench/pclb_link_model.sv
`timescale 1ns/100ps
module pclb_link_model (
   // Link pins
   output logic sys_bit_clk,
   output logic frame_sync_in,
   output logic control_link_in,
   input wire logic control_link_out,
   input wire logic control_link_oe,
   // Frame results
   output logic [7:0] status_byte,
   output logic [7:0] oe_faults
);
   // Free-running 8192 kHz bit clock, four phases per link bit
   initial begin
      sys_bit_clk = 1'b0;
      frame_sync_in = 1'b0;
      control_link_in = 1'b0;
      status_byte = 8'h00;
      oe_faults = 8'h00;
      forever #61 sys_bit_clk = ~sys_bit_clk;
   end

   // Sync, then one command byte in slot 0 of the next frame
   task automatic send_frame(input logic [7:0] cmd);
      int k;
      oe_faults = 8'h00;
      @(negedge sys_bit_clk);
      #2 frame_sync_in = 1'b1;
      for (k = 1; k < 72; k++) begin
         @(negedge sys_bit_clk);
         #2 frame_sync_in = 1'b0;
         // Outside slot 0 the line toggles so stale data never passes
         if (k % 4 == 0)
            control_link_in = (k >= 32 && k < 64) ?
               cmd[7 - (k - 32) / 4] : ~control_link_in;
         if (k % 4 == 2 && k >= 32 && k < 64)
            status_byte = {status_byte[6:0], control_link_out};
         if (k % 4 == 2 && control_link_oe !== (k >= 32 && k < 64))
            oe_faults++;
      end
   endtask
endmodule // pclb_link_model

// ===== testbench/pclb_ctrl_tb_top.sv
`timescale 1ns/100ps
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin \
error_cnt++; $display("CHECK FAILED %s exp %h got %h", n, e, a); end end

module pclb_ctrl_tb_top;
   // Design and model connections
   logic mclk, reset, ce, in_valid, in_ready, out_valid, out_ready;
   logic per_channel_law_mode, global_far_end_law, global_near_end_law;
   logic global_off_law, canceller_disable, nonlinear_off_pin;
   logic nonlinear_off_reg, send_path_skip, receive_path_skip;
   logic receive_to_send_loop, send_to_receive_loop, gp_frame_en;
   logic [31:0] indiv_far_end_law, indiv_near_end_law, conversion_off;
   logic [31:0] channel_off_law, pin_control_gate, channel_disable;
   logic [2:0] tone_action;
   logic [4:0] control_link_frame_offset, control_link_channel_offset;
   logic [4:0] gp_frame_sel;
   logic [1:0] bit_phase_offset;
   logic sys_bit_clk, frame_sync_in, control_link_in, control_link_out;
   logic control_link_oe, gp_strobe, link_locked;
   logic [7:0] gp_byte, status_byte, oe_faults;
   pclb_pkg::pclb_in_t in_word;
   pclb_pkg::pclb_out_t out_word, ow;
   int error_cnt = 0;
   int comparisons = 0;
   int gp_cnt = 0;

   pclb_ctrl u_pclb_ctrl (.*);
   pclb_link_model u_pclb_link_model (.*);

   // 200 MHz system clock
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   // Count strobes on the falling edge, away from the edge that launches them
   always @(negedge mclk) gp_cnt += gp_strobe;

   task automatic tick;
      @(posedge mclk);
      #1;
   endtask

   task automatic stop_test;
      if (error_cnt == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // One sample through the stream, answer kept in ow
   task automatic xfer(input logic [4:0] ch);
      int n;
      in_word.chan = ch;
      in_valid = 1'b1;
      for (n = 0; in_ready !== 1'b1 && n < 50; n++)
         tick;
      `CHK("ready", 1'b1, in_ready)
      tick;
      in_valid = 1'b0;
      for (n = 0; out_valid !== 1'b1 && n < 50; n++)
         tick;
      `CHK("answer", 1'b1, out_valid)
      if (out_valid !== 1'b1)
         stop_test;
      ow = out_word;
      tick;
   endtask

   task automatic t_law;
      int i;
      for (i = 0; i < 4; i++) begin
         global_far_end_law = i[1];
         global_near_end_law = i[0];
         xfer(5'h03);
         `CHK("fe law", i[1], ow.fe_law)
         `CHK("ne law", i[0], ow.ne_law)
      end
      conversion_off[3] = 1'b1;
      xfer(5'h03);
      `CHK("g off", 3'h0, {ow.fe_law, ow.ne_law, ow.conv_on})
      per_channel_law_mode = 1'b1;
      indiv_near_end_law[3] = 1'b1;
      conversion_off[3] = 1'b0;
      xfer(5'h03);
      `CHK("indiv", 3'h3, {ow.fe_law, ow.ne_law, ow.conv_on})
      conversion_off[3] = 1'b1;
      channel_off_law[3] = 1'b1;
      xfer(5'h03);
      `CHK("c off", 3'h6, {ow.fe_law, ow.ne_law, ow.conv_on})
      per_channel_law_mode = 1'b0;
      conversion_off[3] = 1'b0;
      in_word.serial_conv_off = 1'b1;
      xfer(5'h03);
      `CHK("gate 0", 1'b0, ow.conv_on)
      pin_control_gate[3] = 1'b1;
      xfer(5'h03);
      `CHK("gate 1", 1'b1, ow.conv_on)
      in_word.serial_conv_off = 1'b0;
   endtask

   task automatic t_paths;
      {in_word.send_in, in_word.recv_in} = 16'h1133;
      {in_word.ec_send, in_word.ec_recv} = 16'h2244;
      nonlinear_off_pin = 1'b1;
      xfer(5'h03);
      `CHK("nlp pin", 2'h2, {ow.nlp_skip, ow.bypass})
      `CHK("ec data", 16'h2244, {ow.send_out, ow.recv_out})
      nonlinear_off_pin = 1'b0;
      nonlinear_off_reg = 1'b1;
      xfer(5'h03);
      `CHK("nlp reg", 1'b1, ow.nlp_skip)
      nonlinear_off_reg = 1'b0;
      in_word.serial_bypass = 1'b1;
      xfer(5'h03);
      `CHK("clear", 3'h7, {ow.bypass, ow.clear64, ow.conv_on})
      `CHK("byp data", 16'h1133, {ow.send_out, ow.recv_out})
      global_near_end_law = 1'b0;
      xfer(5'h03);
      `CHK("unequal", 1'b0, ow.clear64)
      in_word.serial_bypass = 1'b0;
      channel_disable[3] = 1'b1;
      xfer(5'h03);
      `CHK("ch dis", 3'h7, {ow.bypass, ow.coef_reset, ow.speech_reset})
      channel_disable[3] = 1'b0;
      canceller_disable = 1'b1;
      xfer(5'h03);
      `CHK("all dis", 3'h7, {ow.bypass, ow.coef_reset, ow.conv_on})
      canceller_disable = 1'b0;
   endtask

   task automatic t_modes;
      int i;
      in_word.tone = 1'b1;
      for (i = 0; i < 8; i++) begin
         tone_action = 3'(i);
         xfer(5'h03);
         `CHK("tone", 3'(i), {ow.coef_reset, ow.nlp_skip, ow.bypass})
      end
      in_word.tone = 1'b0;
      tone_action = 3'h0;
      for (i = 0; i < 4; i++) begin
         {send_path_skip, receive_path_skip} = 2'(i);
         {receive_to_send_loop, send_to_receive_loop} = 2'(i);
         xfer(5'h03);
         `CHK("skip", i == 3, ow.full_skip)
         `CHK("loop", {i[1], i == 1}, {ow.loop_rs, ow.loop_sr})
         `CHK("path data", {i[1] ? 8'h11 : 8'h22, i[0] ? 8'h33 : 8'h44},
              {ow.send_out, ow.recv_out})
      end
      {send_path_skip, receive_path_skip} = 2'h0;
      {receive_to_send_loop, send_to_receive_loop} = 2'h0;
      in_word.robbed = 1'b1;
      in_word.send_in = 8'h01;
      in_word.ec_send = 8'hfe;
      xfer(5'h03);
      `CHK("robbed 1", 1'b1, ow.send_out[0])
      in_word.send_in = 8'h00;
      in_word.ec_send = 8'h01;
      xfer(5'h03);
      `CHK("robbed 0", 1'b0, ow.send_out[0])
      in_word.robbed = 1'b0;
   endtask

   // Fill with the sink stalled, then drain in order
   task automatic t_fifo;
      int n, k, m;
      out_ready = 1'b0;
      in_valid = 1'b1;
      k = 0;
      for (n = 0; n < 20; n++) begin
         in_word.chan = 5'(k);
         in_word.mf_begin = k[0];
         if (in_ready === 1'b1)
            k++;
         tick;
      end
      in_valid = 1'b0;
      `CHK("fill", 5, k)
      ce = 1'b0;
      out_ready = 1'b1;
      tick;
      tick;
      `CHK("frozen", 5'h00, out_word.chan)
      ce = 1'b1;
      for (n = 0; n < k; n++) begin
         for (m = 0; out_valid !== 1'b1 && m < 10; m++)
            tick;
         `CHK("order", 5'(n), out_word.chan)
         `CHK("mark", n[0], out_word.mf_begin)
         tick;
      end
      `CHK("empty", 1'b0, out_valid)
      in_word.mf_begin = 1'b0;
   endtask

   task automatic t_link(input logic [4:0] fo, input logic [7:0] cmd);
      control_link_frame_offset = fo;
      u_pclb_link_model.send_frame(cmd);
      `CHK("status", 8'h02, status_byte)
      `CHK("oe", 8'h00, oe_faults)
      `CHK("locked", 1'b1, link_locked)
      xfer(fo + 5'h01);
   endtask

   initial begin
      {reset, ce, out_ready} = 3'h7;
      in_valid = 1'b0;
      in_word = '0;
      {per_channel_law_mode, global_far_end_law, global_near_end_law} = 3'h0;
      {global_off_law, canceller_disable, nonlinear_off_pin} = 3'h0;
      {nonlinear_off_reg, send_path_skip, receive_path_skip} = 3'h0;
      {receive_to_send_loop, send_to_receive_loop, gp_frame_en} = 3'h0;
      {indiv_far_end_law, indiv_near_end_law, conversion_off} = '0;
      {channel_off_law, pin_control_gate, channel_disable} = '0;
      tone_action = 3'h0;
      control_link_frame_offset = 5'h00;
      control_link_channel_offset = 5'h1f;
      gp_frame_sel = 5'h00;
      bit_phase_offset = 2'h0;
      tick;
      tick;
      reset = 1'b0;
      `CHK("idle", 3'h4, {in_ready, out_valid, link_locked})
      `CHK("oe idle", 1'b0, control_link_oe)
      t_law;
      t_paths;
      t_modes;
      t_fifo;
      {global_far_end_law, global_near_end_law} = 2'h2;
      t_link(5'h04, 8'h80);
      `CHK("link dis", 3'h7, {ow.bypass, ow.coef_reset, ow.conv_on})
      t_link(5'h08, 8'h70);
      `CHK("link cmd", 3'h6, {ow.bypass, ow.nlp_skip, ow.conv_on})
      gp_frame_en = 1'b1;
      gp_frame_sel = 5'h0d;
      t_link(5'h0c, 8'h5a);
      `CHK("gp byte", 8'h5a, gp_byte)
      `CHK("gp strobe", 1, gp_cnt)
      `CHK("gp no cmd", 2'h0, {ow.bypass, ow.nlp_skip})
      stop_test;
   end
endmodule // pclb_ctrl_tb_top
